// ==== hdl/kr_pcs_status_registers.sv ====
// KR PCS status, diagnostic counters and pattern seed A low words.
// Assumes an MDIO front end that has already decoded Clause 45 frames
// into one-cycle read and write strobes with device and register address.
`timescale 1ns/1ps
`default_nettype none

module kr_pcs_status_registers #(
  parameter int BAD_HEADER_WIDTH = kr_pcs_status_pkg::BAD_HEADER_COUNT_WIDTH,
  parameter int ERR_BLOCK_WIDTH = kr_pcs_status_pkg::ERRORED_BLOCK_COUNT_WIDTH
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic kr_mode_in,
  input wire logic mgmt_read_in,
  input wire logic mgmt_write_in,
  input wire logic [4:0] mgmt_devad_in,
  input wire logic [15:0] mgmt_addr_in,
  input wire logic [15:0] mgmt_wdata_in,
  input wire logic tx_fault_in,
  input wire logic rx_fault_in,
  input wire logic receive_link_in,
  input wire logic block_lock_in,
  input wire logic high_error_rate_in,
  input wire logic bad_header_entry_in,
  input wire logic rx_error_entry_in,
  output logic [15:0] mgmt_rdata_out,
  output logic mgmt_ack_out,
  output logic mgmt_hit_out,
  output logic [31:0] pattern_seed_a_out,
  output logic fault_summary_out
);

  // Field widths are fixed by the register layout
  if (BAD_HEADER_WIDTH != kr_pcs_status_pkg::BAD_HEADER_COUNT_WIDTH ||
      ERR_BLOCK_WIDTH != kr_pcs_status_pkg::ERRORED_BLOCK_COUNT_WIDTH)
  begin : g_width_refused
    $error("kr_pcs_status_registers: counter widths must be 6 and 8");
  end

  // Address decode from device address and register offset
  function automatic kr_pcs_status_pkg::reg_sel_t decode_reg(
    input logic [4:0] devad,
    input logic [15:0] addr
  );
    kr_pcs_status_pkg::reg_sel_t sel;
    sel = kr_pcs_status_pkg::SEL_NONE;
    if (devad == kr_pcs_status_pkg::DEVAD_PCS)
    begin
      case (addr)
        kr_pcs_status_pkg::OFF_PCS_STATUS_FIRST:
          sel = kr_pcs_status_pkg::SEL_PCS_STATUS_FIRST;
        kr_pcs_status_pkg::OFF_PCS_STATUS_SECOND:
          sel = kr_pcs_status_pkg::SEL_PCS_STATUS_SECOND;
        kr_pcs_status_pkg::OFF_KR_STATUS_FIRST:
          sel = kr_pcs_status_pkg::SEL_KR_STATUS_FIRST;
        kr_pcs_status_pkg::OFF_KR_STATUS_SECOND:
          sel = kr_pcs_status_pkg::SEL_KR_STATUS_SECOND;
        kr_pcs_status_pkg::OFF_SEED_A_WORD0:
          sel = kr_pcs_status_pkg::SEL_SEED_A_WORD0;
        kr_pcs_status_pkg::OFF_SEED_A_WORD1:
          sel = kr_pcs_status_pkg::SEL_SEED_A_WORD1;
        default:
          sel = kr_pcs_status_pkg::SEL_NONE;
      endcase
    end
    else if (devad == kr_pcs_status_pkg::DEVAD_VENDOR &&
             addr == kr_pcs_status_pkg::OFF_ERR_BLOCK_ALIAS)
    begin
      sel = kr_pcs_status_pkg::SEL_ERR_BLOCK_ALIAS;
    end
    return sel;
  endfunction : decode_reg

  kr_pcs_status_pkg::reg_sel_t sel;
  logic rd_go;
  logic wr_go;
  logic rd_status_second;
  logic rd_kr_second;
  logic rd_err_block;
  logic any_fault;

  // Accesses count only in KR mode
  assign sel = kr_mode_in ? decode_reg(mgmt_devad_in, mgmt_addr_in)
                          : kr_pcs_status_pkg::SEL_NONE;
  assign rd_go = mgmt_read_in;
  assign wr_go = mgmt_write_in && !mgmt_read_in;
  assign rd_status_second = rd_go &&
    (sel == kr_pcs_status_pkg::SEL_PCS_STATUS_SECOND);
  assign rd_kr_second = rd_go &&
    (sel == kr_pcs_status_pkg::SEL_KR_STATUS_SECOND);
  assign rd_err_block = rd_kr_second ||
    (rd_go && sel == kr_pcs_status_pkg::SEL_ERR_BLOCK_ALIAS);
  assign any_fault = tx_fault_in || rx_fault_in;

  logic fault_summary_r;
  logic receive_link_latched_r;
  logic transmit_fault_latched_r;
  logic receive_fault_latched_r;
  logic block_lock_latched_r;
  logic high_error_rate_latched_r;
  // Fault summary: new fault wins over the clearing read
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fault_summary_r <= 1'b0;
    end
    else if (ce_in)
    begin
      fault_summary_r <= any_fault |
        (fault_summary_r & !rd_status_second);
    end
  end

  // Latched-high fault bits of the second PCS status register
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      transmit_fault_latched_r <= 1'b0;
      receive_fault_latched_r <= 1'b0;
    end
    else if (ce_in)
    begin
      transmit_fault_latched_r <= tx_fault_in |
        (transmit_fault_latched_r & !rd_status_second);
      receive_fault_latched_r <= rx_fault_in |
        (receive_fault_latched_r & !rd_status_second);
    end
  end

  // Latched-low receive link of the first PCS status register
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      receive_link_latched_r <= 1'b0;
    end
    else if (ce_in)
    begin
      receive_link_latched_r <= receive_link_in &
        (receive_link_latched_r |
         (rd_go && sel == kr_pcs_status_pkg::SEL_PCS_STATUS_FIRST));
    end
  end

  // Latched copies of block lock and high error rate
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      block_lock_latched_r <= 1'b0;
      high_error_rate_latched_r <= 1'b0;
    end
    else if (ce_in)
    begin
      block_lock_latched_r <= block_lock_in &
        (block_lock_latched_r | rd_kr_second);
      high_error_rate_latched_r <= high_error_rate_in |
        (high_error_rate_latched_r & !rd_kr_second);
    end
  end

  logic [BAD_HEADER_WIDTH-1:0] bad_header_entry_count;
  logic [ERR_BLOCK_WIDTH-1:0] errored_block_count;

  // Bad sync header state entry counter
  sat_clear_counter #(
    .WIDTH(BAD_HEADER_WIDTH)
  ) u_bad_header_count (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .event_in(bad_header_entry_in),
    .clear_in(rd_kr_second),
    .count_out(bad_header_entry_count)
  );

  // Errored block counter, shared by both read locations
  sat_clear_counter #(
    .WIDTH(ERR_BLOCK_WIDTH)
  ) u_errored_block_count (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .event_in(rx_error_entry_in),
    .clear_in(rd_err_block),
    .count_out(errored_block_count)
  );

  logic [15:0] seed_word0_r;
  logic [15:0] seed_word1_r;
  // Pattern seed A low words, written by the station
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      seed_word0_r <= kr_pcs_status_pkg::RST_SEED_WORD;
      seed_word1_r <= kr_pcs_status_pkg::RST_SEED_WORD;
    end
    else if (ce_in && wr_go)
    begin
      if (sel == kr_pcs_status_pkg::SEL_SEED_A_WORD0)
        seed_word0_r <= mgmt_wdata_in;
      if (sel == kr_pcs_status_pkg::SEL_SEED_A_WORD1)
        seed_word1_r <= mgmt_wdata_in;
    end
  end

  logic [15:0] pcs_status_first;
  logic [15:0] pcs_status_second;
  logic [15:0] kr_pcs_status_first;
  logic [15:0] kr_pcs_status_second;
  // Read images; reserved bits read zero
  always_comb
  begin
    pcs_status_first = '0;
    pcs_status_first[kr_pcs_status_pkg::BIT_FAULT_SUMMARY] =
      fault_summary_r;
    pcs_status_first[kr_pcs_status_pkg::BIT_RECEIVE_LINK_LATCHED] =
      receive_link_latched_r;
    pcs_status_first[kr_pcs_status_pkg::BIT_LOW_POWER_SUPPORTED] =
      1'b1;
    pcs_status_second = '0;
    pcs_status_second[kr_pcs_status_pkg::BIT_DEVICE_RESPONDING_HI:
                      kr_pcs_status_pkg::BIT_DEVICE_RESPONDING_LO] =
      kr_pcs_status_pkg::DEVICE_RESPONDING_CODE;
    pcs_status_second[kr_pcs_status_pkg::BIT_TRANSMIT_FAULT_LATCHED] =
      transmit_fault_latched_r;
    pcs_status_second[kr_pcs_status_pkg::BIT_RECEIVE_FAULT_LATCHED] =
      receive_fault_latched_r;
    pcs_status_second[kr_pcs_status_pkg::BIT_BASE_R_TYPE_SUPPORTED] =
      1'b1;
    kr_pcs_status_first = '0;
    kr_pcs_status_first[kr_pcs_status_pkg::BIT_RECEIVE_LINK_LIVE] =
      receive_link_in;
    kr_pcs_status_first[kr_pcs_status_pkg::BIT_PRBS_TESTING_SUPPORTED] =
      1'b1;
    kr_pcs_status_first[kr_pcs_status_pkg::BIT_HIGH_ERROR_RATE_LIVE] =
      high_error_rate_in;
    kr_pcs_status_first[kr_pcs_status_pkg::BIT_BLOCK_LOCK_LIVE] =
      block_lock_in;
    kr_pcs_status_second = '0;
    kr_pcs_status_second[kr_pcs_status_pkg::BIT_BLOCK_LOCK_LATCHED] =
      block_lock_latched_r;
    kr_pcs_status_second[kr_pcs_status_pkg::BIT_HIGH_ERROR_RATE_LATCHED] =
      high_error_rate_latched_r;
    kr_pcs_status_second[kr_pcs_status_pkg::BAD_HEADER_COUNT_LSB +:
                         BAD_HEADER_WIDTH] = bad_header_entry_count;
    kr_pcs_status_second[kr_pcs_status_pkg::ERRORED_BLOCK_COUNT_LSB +:
                         ERR_BLOCK_WIDTH] = errored_block_count;
  end

  logic [15:0] rdata_nxt;

  // Read multiplexer; unmapped locations read the idle value
  always_comb
  begin
    rdata_nxt = kr_pcs_status_pkg::NO_ANSWER_DATA;
    case (sel)
      kr_pcs_status_pkg::SEL_PCS_STATUS_FIRST:
        rdata_nxt = pcs_status_first;
      kr_pcs_status_pkg::SEL_PCS_STATUS_SECOND:
        rdata_nxt = pcs_status_second;
      kr_pcs_status_pkg::SEL_KR_STATUS_FIRST:
        rdata_nxt = kr_pcs_status_first;
      kr_pcs_status_pkg::SEL_KR_STATUS_SECOND:
        rdata_nxt = kr_pcs_status_second;
      kr_pcs_status_pkg::SEL_SEED_A_WORD0:
        rdata_nxt = seed_word0_r;
      kr_pcs_status_pkg::SEL_SEED_A_WORD1:
        rdata_nxt = seed_word1_r;
      kr_pcs_status_pkg::SEL_ERR_BLOCK_ALIAS:
        rdata_nxt = 16'(errored_block_count);
      default:
        rdata_nxt = kr_pcs_status_pkg::NO_ANSWER_DATA;
    endcase
  end

  logic [15:0] rdata_r;
  logic ack_r;
  logic hit_r;

  // Answer register: one-cycle acknowledge after each strobe taken with ce_in high
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_r <= '0;
      ack_r <= 1'b0;
      hit_r <= 1'b0;
    end
    else if (ce_in)
    begin
      ack_r <= rd_go || wr_go;
      hit_r <= (rd_go || wr_go) &&
               (sel != kr_pcs_status_pkg::SEL_NONE);
      if (rd_go)
        rdata_r <= rdata_nxt;
    end
  end

  assign mgmt_rdata_out = rdata_r;
  assign mgmt_ack_out = ack_r;
  assign mgmt_hit_out = hit_r;
  assign pattern_seed_a_out = {seed_word1_r, seed_word0_r};
  assign fault_summary_out = fault_summary_r;

endmodule : kr_pcs_status_registers

`default_nettype wire

// ==== hdl/kr_pcs_status_pkg.sv ====
// Constants for the KR PCS status and diagnostic register bank.
// Assumes a 16-bit management word and Clause 45 device addressing.
package kr_pcs_status_pkg;

  // Device address spaces
  localparam logic [4:0] DEVAD_PCS = 5'h03;
  localparam logic [4:0] DEVAD_VENDOR = 5'h1E;

  // Register offsets inside the PCS space
  localparam logic [15:0] OFF_PCS_STATUS_FIRST = 16'h0001;
  localparam logic [15:0] OFF_PCS_STATUS_SECOND = 16'h0008;
  localparam logic [15:0] OFF_KR_STATUS_FIRST = 16'h0020;
  localparam logic [15:0] OFF_KR_STATUS_SECOND = 16'h0021;
  localparam logic [15:0] OFF_SEED_A_WORD0 = 16'h0022;
  localparam logic [15:0] OFF_SEED_A_WORD1 = 16'h0023;
  // Errored-block count alias in the vendor space
  localparam logic [15:0] OFF_ERR_BLOCK_ALIAS = 16'h0010;

  // Values after reset
  localparam logic [15:0] RST_PCS_STATUS_FIRST = 16'h0002;
  localparam logic [15:0] RST_PCS_STATUS_SECOND = 16'h8001;
  localparam logic [15:0] RST_KR_STATUS_FIRST = 16'h0004;
  localparam logic [15:0] RST_KR_STATUS_SECOND = 16'h0000;
  localparam logic [15:0] RST_SEED_WORD = 16'h0000;

  // Read data when nothing answers (idle line reads high)
  localparam logic [15:0] NO_ANSWER_DATA = 16'hFFFF;

  // First PCS status register fields
  localparam int BIT_FAULT_SUMMARY = 7;
  localparam int BIT_RECEIVE_LINK_LATCHED = 2;
  localparam int BIT_LOW_POWER_SUPPORTED = 1;

  // Second PCS status register fields
  localparam int BIT_DEVICE_RESPONDING_HI = 15;
  localparam int BIT_DEVICE_RESPONDING_LO = 14;
  localparam logic [1:0] DEVICE_RESPONDING_CODE = 2'h2;
  localparam int BIT_TRANSMIT_FAULT_LATCHED = 11;
  localparam int BIT_RECEIVE_FAULT_LATCHED = 10;
  localparam int BIT_BASE_R_TYPE_SUPPORTED = 0;

  // First KR PCS status register fields
  localparam int BIT_RECEIVE_LINK_LIVE = 12;
  localparam int BIT_PRBS_TESTING_SUPPORTED = 2;
  localparam int BIT_HIGH_ERROR_RATE_LIVE = 1;
  localparam int BIT_BLOCK_LOCK_LIVE = 0;

  // Second KR PCS status register fields
  localparam int BIT_BLOCK_LOCK_LATCHED = 15;
  localparam int BIT_HIGH_ERROR_RATE_LATCHED = 14;
  localparam int BAD_HEADER_COUNT_LSB = 8;
  localparam int BAD_HEADER_COUNT_WIDTH = 6;
  localparam int ERRORED_BLOCK_COUNT_LSB = 0;
  localparam int ERRORED_BLOCK_COUNT_WIDTH = 8;

  // Register selection produced by the address decode
  typedef enum logic [2:0]
  {
    SEL_NONE,
    SEL_PCS_STATUS_FIRST,
    SEL_PCS_STATUS_SECOND,
    SEL_KR_STATUS_FIRST,
    SEL_KR_STATUS_SECOND,
    SEL_SEED_A_WORD0,
    SEL_SEED_A_WORD1,
    SEL_ERR_BLOCK_ALIAS
  } reg_sel_t;

endpackage : kr_pcs_status_pkg

// ==== hdl/sat_clear_counter.sv ====
// Saturating event counter that clears when its owner reads it.
// Assumes event and clear are single-cycle strobes on clock_in.
`timescale 1ns/1ps
`default_nettype none

module sat_clear_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic event_in,
  input wire logic clear_in,
  output logic [WIDTH-1:0] count_out
);

  // Refuse widths the counter cannot serve
  initial
  begin
    if (WIDTH < 1 || WIDTH > 16)
    begin
      $error("sat_clear_counter: WIDTH must lie in 1..16");
    end
  end

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic at_max;

  assign at_max = &count_r;

  // Next count: an event in the clearing cycle counts as one
  always_comb
  begin
    count_nxt = count_r;
    if (clear_in)
    begin
      count_nxt = event_in ? WIDTH'(1) : '0;
    end
    else if (event_in && !at_max)
    begin
      count_nxt = count_r + WIDTH'(1);
    end
  end

  // Count register
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_r <= '0;
    end
    else if (ce_in)
    begin
      count_r <= count_nxt;
    end
  end

  assign count_out = count_r;

endmodule : sat_clear_counter

`default_nettype wire

// ==== test/kr_pcs_status_registers_chk.sv ====
// Checker for the KR PCS status register bank, bound to its top ports.
// Assumes decoded strobes and a one-cycle registered answer.
`timescale 1ns/1ps
`default_nettype none

module kr_pcs_status_registers_chk (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic kr_mode_in,
  input wire logic mgmt_read_in,
  input wire logic mgmt_write_in,
  input wire logic [4:0] mgmt_devad_in,
  input wire logic [15:0] mgmt_addr_in,
  input wire logic [15:0] mgmt_wdata_in,
  input wire logic tx_fault_in,
  input wire logic rx_fault_in,
  input wire logic [15:0] mgmt_rdata_out,
  input wire logic mgmt_ack_out,
  input wire logic mgmt_hit_out,
  input wire logic [31:0] pattern_seed_a_out,
  input wire logic fault_summary_out
);
  logic rd_pcs;
  logic wr_pcs;

  // Taken accesses aimed at the PCS space in KR mode
  assign rd_pcs = ce_in && mgmt_read_in && kr_mode_in &&
    mgmt_devad_in == 5'h03;
  assign wr_pcs = ce_in && mgmt_write_in && !mgmt_read_in && kr_mode_in &&
    mgmt_devad_in == 5'h03;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  ack_after_req_a: assert property (
    (ce_in && (mgmt_read_in || mgmt_write_in)) |=> mgmt_ack_out)
    else $error("no answer after a request");
  ack_only_req_a: assert property (
    (ce_in && !mgmt_read_in && !mgmt_write_in) |=> !mgmt_ack_out)
    else $error("answer without a request");
  kr_off_refuse_a: assert property (
    (ce_in && mgmt_read_in && !kr_mode_in)
    |=> !mgmt_hit_out && mgmt_rdata_out == 16'hFFFF)
    else $error("register answered outside KR mode");
  devad_refuse_a: assert property (
    (ce_in && mgmt_read_in && mgmt_devad_in != 5'h03 &&
     mgmt_devad_in != 5'h1E) |=> !mgmt_hit_out)
    else $error("foreign device address answered");
  status2_const_a: assert property (
    (rd_pcs && mgmt_addr_in == 16'h0008)
    |=> mgmt_rdata_out[15:14] == 2'b10 && mgmt_rdata_out[0])
    else $error("fixed fields of status two wrong");
  low_power_a: assert property (
    (rd_pcs && mgmt_addr_in == 16'h0001) |=> mgmt_rdata_out[1])
    else $error("low power capability bit wrong");
  prbs_cap_a: assert property (
    (rd_pcs && mgmt_addr_in == 16'h0020) |=> mgmt_rdata_out[2])
    else $error("pattern capability bit wrong");
  fault_set_a: assert property (
    (ce_in && (tx_fault_in || rx_fault_in)) |=> fault_summary_out)
    else $error("fault summary missed a fault");
  fault_hold_a: assert property (
    (fault_summary_out && !(rd_pcs && mgmt_addr_in == 16'h0008))
    |=> fault_summary_out)
    else $error("fault summary cleared without a read");
  seed_low_wr_a: assert property (
    (wr_pcs && mgmt_addr_in == 16'h0022)
    |=> pattern_seed_a_out[15:0] == $past(mgmt_wdata_in))
    else $error("seed low word not written");

  // Main scenarios reached
  cover property (rd_pcs && mgmt_addr_in == 16'h0021);
  cover property (mgmt_ack_out && !mgmt_hit_out);
  cover property (fault_summary_out ##1 !fault_summary_out);
endmodule : kr_pcs_status_registers_chk

`default_nettype wire

// ==== test/mgmt_station.sv ====
// Management station model issuing decoded Clause 45 strobes.
// Assumes the bank registers its answer on the same edge that takes a strobe.
`timescale 1ns/1ps
`default_nettype none

module mgmt_station (
  input wire logic clock_in,
  input wire logic [15:0] rdata_in,
  input wire logic ack_in,
  input wire logic hit_in,
  output logic read_out,
  output logic write_out,
  output logic [4:0] devad_out,
  output logic [15:0] addr_out,
  output logic [15:0] wdata_out
);
  // Idle lines at time zero
  initial
  begin
    read_out = 1'b0;
    write_out = 1'b0;
    devad_out = 5'h00;
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
  end

  // One request held to its taken edge, answer sampled after it
  task access(input logic wr, input logic [4:0] dv, input logic [15:0] ad,
    input logic [15:0] wd, output logic [15:0] rd, output logic ok,
    output logic ak);
    @(posedge clock_in);
    read_out <= !wr;
    write_out <= wr;
    devad_out <= dv;
    addr_out <= ad;
    wdata_out <= wd;
    @(posedge clock_in);
    read_out <= 1'b0;
    write_out <= 1'b0;
    devad_out <= ~dv; // Released lines stop showing the request
    addr_out <= ~ad;
    wdata_out <= ~wd;
    #1;
    rd = rdata_in;
    ok = hit_in;
    ak = ack_in;
  endtask : access
endmodule : mgmt_station

`default_nettype wire

// ==== test/tb_kr_pcs_status_registers.sv ====
// Self-checking bench for the KR PCS status register bank.
// Assumes the station model drives strobes and a queue holds answers.
`timescale 1ns/1ps
`default_nettype none

module tb_kr_pcs_status_registers;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic kr_mode_in = 1'b1;
  logic tx_fault_in = 1'b0;
  logic rx_fault_in = 1'b0;
  logic receive_link_in = 1'b0;
  logic block_lock_in = 1'b0;
  logic high_error_rate_in = 1'b0;
  logic bad_header_entry_in = 1'b0;
  logic rx_error_entry_in = 1'b0;
  logic mgmt_read_in;
  logic mgmt_write_in;
  logic [4:0] mgmt_devad_in;
  logic [15:0] mgmt_addr_in;
  logic [15:0] mgmt_wdata_in;
  logic [15:0] mgmt_rdata_out;
  logic mgmt_ack_out;
  logic mgmt_hit_out;
  logic [31:0] pattern_seed_a_out;
  logic fault_summary_out;
  integer seed = 32'h6B22;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int mode = 0;
  int sel;
  int bh = 0;
  int eb = 0;
  bit fs, lk, tf, rf, bl, hb;
  logic [15:0] s0 = 16'h0000;
  logic [15:0] s1 = 16'h0000;
  logic [15:0] img;
  logic [16:0] expq[$];
  logic [15:0] maps[8] = '{16'h0001, 16'h0008, 16'h0020, 16'h0021,
    16'h0022, 16'h0023, 16'h0010, 16'h0002};
  logic [15:0] rsts[6] = '{16'h0002, 16'h8001, 16'h0004, 16'h0000,
    16'h0000, 16'h0000};
  logic [31:0] r;
  logic [15:0] d;

  kr_pcs_status_registers i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .ce_in(ce_in), .kr_mode_in(kr_mode_in), .mgmt_read_in(mgmt_read_in),
    .mgmt_write_in(mgmt_write_in), .mgmt_devad_in(mgmt_devad_in),
    .mgmt_addr_in(mgmt_addr_in), .mgmt_wdata_in(mgmt_wdata_in),
    .tx_fault_in(tx_fault_in), .rx_fault_in(rx_fault_in),
    .receive_link_in(receive_link_in), .block_lock_in(block_lock_in),
    .high_error_rate_in(high_error_rate_in),
    .bad_header_entry_in(bad_header_entry_in),
    .rx_error_entry_in(rx_error_entry_in), .mgmt_rdata_out(mgmt_rdata_out),
    .mgmt_ack_out(mgmt_ack_out), .mgmt_hit_out(mgmt_hit_out),
    .pattern_seed_a_out(pattern_seed_a_out),
    .fault_summary_out(fault_summary_out));

  mgmt_station i_sta (.clock_in(clock_in), .rdata_in(mgmt_rdata_out),
    .ack_in(mgmt_ack_out), .hit_in(mgmt_hit_out), .read_out(mgmt_read_in),
    .write_out(mgmt_write_in), .devad_out(mgmt_devad_in),
    .addr_out(mgmt_addr_in), .wdata_out(mgmt_wdata_in));

  // 200 MHz clock
  always #2.5 clock_in = ~clock_in;

  // Condition inputs: quiet, random, event storm, or storm while frozen
  always @(posedge clock_in)
  begin
    r = $random(seed);
    tx_fault_in <= mode == 1 && r[3:0] == 4'h0;
    rx_fault_in <= mode == 1 && r[7:4] == 4'h0;
    receive_link_in <= mode == 1 && r[10:8] != 3'h0;
    block_lock_in <= mode == 1 && r[13:11] != 3'h0;
    high_error_rate_in <= mode == 1 && r[17:14] == 4'h0;
    bad_header_entry_in <= mode >= 2 || (mode == 1 && r[19:18] == 2'h0);
    rx_error_entry_in <= mode >= 2 || (mode == 1 && r[21:20] == 2'h0);
    kr_mode_in <= mode != 1 || r[26:22] != 5'h00;
    ce_in <= mode != 3;
  end

  // Reference model, stepped on every edge out of reset with ce_in high
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      end_of_test();
    end
    if (!rst_n_in)
    begin
      {fs, lk, tf, rf, bl, hb} = 6'h00;
      bh = 0;
      eb = 0;
    end
    else if (ce_in && (mgmt_read_in || mgmt_write_in))
    begin
      sel = 0;
      img = 16'hFFFF;
      case ({mgmt_devad_in, mgmt_addr_in})
        {5'h03, 16'h0001}: {sel, img} = {32'd1, 8'h00, fs, 4'h0, lk, 2'b10};
        {5'h03, 16'h0008}: {sel, img} = {32'd2, 4'h8, tf, rf, 9'h000, 1'b1};
        {5'h03, 16'h0020}: {sel, img} = {32'd3, 3'h0, receive_link_in, 9'h000,
          1'b1, high_error_rate_in, block_lock_in};
        {5'h03, 16'h0021}: {sel, img} = {32'd4, bl, hb, bh[5:0], eb[7:0]};
        {5'h03, 16'h0022}: {sel, img} = {32'd5, s0};
        {5'h03, 16'h0023}: {sel, img} = {32'd6, s1};
        {5'h1E, 16'h0010}: {sel, img} = {32'd7, 8'h00, eb[7:0]};
        default: sel = 0;
      endcase
      if (!kr_mode_in)
      begin
        sel = 0;
        img = 16'hFFFF;
      end
      expq.push_back({sel != 0, img});
      if (!mgmt_read_in)
        sel = sel + 10;
      if (sel == 15)
        s0 = mgmt_wdata_in;
      if (sel == 16)
        s1 = mgmt_wdata_in;
    end
    else
      sel = 0;
    // Latches reload on their read, else collect the live condition
    if (rst_n_in && ce_in)
    begin
      fs = sel == 2 ? tx_fault_in | rx_fault_in :
        fs | tx_fault_in | rx_fault_in;
      tf = sel == 2 ? tx_fault_in : tf | tx_fault_in;
      rf = sel == 2 ? rx_fault_in : rf | rx_fault_in;
      lk = sel == 1 ? receive_link_in : lk & receive_link_in;
      bl = sel == 4 ? block_lock_in : bl & block_lock_in;
      hb = sel == 4 ? high_error_rate_in :
        hb | high_error_rate_in;
      bh = sel == 4 ? bad_header_entry_in :
        bh + (bh < 63 ? bad_header_entry_in : 0);
      eb = sel == 4 || sel == 7 ? rx_error_entry_in :
        eb + (eb < 255 ? rx_error_entry_in : 0);
    end
  end

  // Compare one value, counting it
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One access through the station, checked against the model
  task xfer(input logic wr, input logic [4:0] dv, input logic [15:0] ad,
    input logic [15:0] wd);
    logic ok;
    logic ak;
    logic [16:0] e;
    i_sta.access(wr, dv, ad, wd, d, ok, ak);
    e = expq.pop_front();
    chk({14'h0000, ak, ok}, {14'h0000, 1'b1, e[16]});
    chk({15'h0000, fault_summary_out}, {15'h0000, fs});
    if (!wr)
      chk(d, e[15:0]);
  endtask : xfer

  // Verdict and end of run
  task end_of_test;
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b0, 5'h03, maps[i], 16'h0000);
      chk(d, rsts[i]);
    end
    xfer(1'b1, 5'h03, 16'h0022, 16'hA5C3);
    xfer(1'b1, 5'h03, 16'h0023, 16'h3C5A);
    chk(pattern_seed_a_out[31:16], 16'h3C5A);
    chk(pattern_seed_a_out[15:0], 16'hA5C3);
    mode = 1;
    for (int i = 0; i < 700; i++)
    begin
      r = $random(seed);
      xfer(r[0], r[2:1] != 2'h0 ? 5'h03 : (r[3] ? 5'h1E : 5'h01),
        maps[r[6:4]], r[31:16]);
    end
    chk(pattern_seed_a_out[15:0], s0);
    chk(pattern_seed_a_out[31:16], s1);
    mode = 2;
    repeat (300) @(posedge clock_in);
    xfer(1'b0, 5'h03, 16'h0021, 16'h0000);
    chk({2'b00, d[13:0]}, 16'h3FFF);
    xfer(1'b0, 5'h1E, 16'h0010, 16'h0000);
    mode = 3;
    repeat (20) @(posedge clock_in);
    mode = 0;
    xfer(1'b0, 5'h1E, 16'h0010, 16'h0000);
    xfer(1'b0, 5'h03, 16'h0021, 16'h0000);
    end_of_test();
  end
endmodule : tb_kr_pcs_status_registers

bind kr_pcs_status_registers kr_pcs_status_registers_chk i_chk (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .kr_mode_in(kr_mode_in), .mgmt_read_in(mgmt_read_in),
  .mgmt_write_in(mgmt_write_in), .mgmt_devad_in(mgmt_devad_in),
  .mgmt_addr_in(mgmt_addr_in), .mgmt_wdata_in(mgmt_wdata_in),
  .tx_fault_in(tx_fault_in), .rx_fault_in(rx_fault_in),
  .mgmt_rdata_out(mgmt_rdata_out), .mgmt_ack_out(mgmt_ack_out),
  .mgmt_hit_out(mgmt_hit_out), .pattern_seed_a_out(pattern_seed_a_out),
  .fault_summary_out(fault_summary_out));

`default_nettype wire
